/* pkg/iop_pkg.sv */
// Shared constants and types for the I/O pin routing and test mode registers.
package iop_pkg;

	localparam int          IOP_PINS      = 8;
	localparam int          IOP_FUNCS     = 32;
	localparam logic [9:0]  ADDR_PIN0     = 10'h00f;
	localparam logic [9:0]  ADDR_PIN7     = 10'h016;
	localparam logic [9:0]  ADDR_TEST0    = 10'h055;

	// Route register layout: direction in the top bit, function in the five below.
	localparam int          ROUTE_DIR_BIT = 5;
	localparam int          ROUTE_FN_MSB  = 4;

	// Route reset values: F, V, H on pins 0..2, EDH on pin 5, pin 7 an input.
	localparam logic [5:0]  RST_PIN0      = 6'h12;
	localparam logic [5:0]  RST_PIN1      = 6'h13;
	localparam logic [5:0]  RST_PIN2      = 6'h14;
	localparam logic [5:0]  RST_PIN3      = 6'h00;
	localparam logic [5:0]  RST_PIN4      = 6'h00;
	localparam logic [5:0]  RST_PIN5      = 6'h04;
	localparam logic [5:0]  RST_PIN6      = 6'h00;
	localparam logic [5:0]  RST_PIN7      = 6'h20;

	// Test mode enable bit positions and their default.
	localparam int          TEN_SCRAMBLE  = 0;
	localparam int          TEN_NRZI      = 1;
	localparam int          TEN_LSB_CLIP  = 2;
	localparam int          TEN_SYNC_DET  = 3;
	localparam logic [3:0]  TEST_EN_RST   = 4'hf;

	// Pattern select word fields.
	localparam int          PAT_HD_BIT    = 5;
	localparam int          PAT_PP_BIT    = 4;

	typedef enum logic [2:0]
	{
		ST_ADDR  = 3'h1,
		ST_WDATA = 3'h2,
		ST_RDATA = 3'h4
	} iop_bus_st_t;

	typedef enum logic [1:0]
	{
		PAT_BLACK = 2'h0,
		PAT_PLL   = 2'h1,
		PAT_EQ    = 2'h2,
		PAT_BARS  = 2'h3
	} iop_pat_kind_t;

	typedef struct packed
	{
		logic          hd;
		logic          prog_pal;
		logic [1:0]    sub_format;
		iop_pat_kind_t kind;
	} iop_pat_t;

	typedef struct packed
	{
		logic anc_or_control_select;
		logic rd_wr;
		logic aclk;
	} iop_port_ctl_t;

endpackage : iop_pkg

/* verilog/iop_pin_route.sv */
// One multi-function port pin: output selection and input steering.
`timescale 1ns/100ps
module iop_pin_route
(
	// Route setting
	input  wire logic [5:0]  route,
	// Status and pin
	input  wire logic [31:0] status_bits,
	input  wire logic        pin_in,
	// Results
	output logic             drive_val,
	output logic             drive_en,
	output logic [31:0]      in_hot
);
	import iop_pkg::*;

	logic [4:0] fn;

	always_comb
	begin
		fn        = route[ROUTE_FN_MSB:0];                       // RULE4
		drive_en  = ~route[ROUTE_DIR_BIT];                       // RULE2
		drive_val = status_bits[fn];                             // RULE6
		in_hot    = '0;
		if (route[ROUTE_DIR_BIT])
		begin
			in_hot[fn] = 1'b1;                                   // RULE2
		end
		// Pin level is combined in the parent; kept here for symmetry of the interface.
		if (pin_in)
		begin
			in_hot = in_hot;
		end
	end

endmodule : iop_pin_route

/* verilog/iop_regs.sv */
// Register bank for port pin routing, datapath test enables and pattern decode.
`timescale 1ns/100ps
// Operation
// RULE1 - Eight pin route registers at consecutive addresses, one per port pin.
// RULE2 - Route top bit one makes the pin an input, zero an output.
// RULE3 - Host never maps input-only functions to outputs or the reverse.
// RULE4 - Low five route bits choose the connected control function.
// RULE5 - Host writes: select low, rd_wr low, address strobe, then data strobe.
// RULE6 - Data written to a route register is the target bit address.
// RULE7 - Test register holds four enables, each settable by host write.
// RULE8 - Reading the test register forces all four enables back on.
// RULE9 - Scrambler enable gates scrambling; default on.
// RULE10 - Polarity coding enable gates NRZ to NRZI conversion; default on.
// RULE11 - Low-bit clipping enable gates LSB clipping; default on.
// RULE12 - Timing reference detect enable gates TRS detector; default on.
// RULE13 - Pattern word: bit5 HD, bit4 progressive/PAL, bits3:2 sub-format, bits1:0 kind.
// RULE14 - Pattern select applies while pattern generator or self check is enabled.
module iop_regs
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  resetn,
	// Ancillary/control data port
	input  wire iop_pkg::iop_port_ctl_t port_ctl,
	input  wire logic [9:0]            ad_in,
	output logic [9:0]                 ad_out,
	output logic                       ad_oe,
	// Multi-function port
	input  wire logic [7:0]            io_in,
	output logic [7:0]                 io_out,
	output logic [7:0]                 io_oe,
	// Control and status bits of the device
	input  wire logic [31:0]           status_bits,
	output logic [31:0]                pin_ctrl_val,
	output logic [31:0]                pin_ctrl_valid,
	// Datapath enables
	output logic                       scrambler_en,
	output logic                       nrzi_en,
	output logic                       lsb_clip_en,
	output logic                       sync_detect_en,
	// Test pattern
	input  wire logic [5:0]            pattern_select,
	input  wire logic                  pattern_generator_en,
	input  wire logic                  built_in_self_check_en,
	output iop_pkg::iop_pat_t          pattern_cfg,
	output logic                       pattern_active
);
	import iop_pkg::*;

	typedef struct packed
	{
		iop_bus_st_t     st;
		logic [9:0]      addr;
		logic [7:0][5:0] route;
		logic [3:0]      test_en;
		logic            aclk_q;
		logic [9:0]      ad_o;
		logic            ad_oe;
		logic [7:0]      io_o;
		logic [7:0]      io_oe;
		logic [31:0]     ctrl_val;
		logic [31:0]     ctrl_valid;
		iop_pat_t        pat;
		logic            pat_act;
	} iop_state_t;

	iop_state_t      st_ff;
	iop_state_t      nxt_st;
	logic [7:0]      drv_val;
	logic [7:0]      drv_en;
	logic [7:0][31:0] in_hot;
	logic            strobe;
	logic            is_pin;
	logic [2:0]      pin_idx;
	logic [9:0]      rd_data;

	genvar g;
	generate
		for (g = 0; g < IOP_PINS; g++)
		begin : g_pin
			iop_pin_route iop_pin_route_inst
			(
				.route       (st_ff.route[g]),
				.status_bits (status_bits),
				.pin_in      (io_in[g]),
				.drive_val   (drv_val[g]),
				.drive_en    (drv_en[g]),
				.in_hot      (in_hot[g])
			);
		end
	endgenerate

	always_comb
	begin
		strobe  = port_ctl.aclk & ~st_ff.aclk_q;
		is_pin  = (st_ff.addr >= ADDR_PIN0) && (st_ff.addr <= ADDR_PIN7);   // RULE1
		pin_idx = 3'(st_ff.addr - ADDR_PIN0);
		rd_data = '0;
		if (is_pin)
		begin
			rd_data = {4'h0, st_ff.route[pin_idx]};
		end
		else if (st_ff.addr == ADDR_TEST0)
		begin
			rd_data = {6'h00, st_ff.test_en};
		end

		nxt_st        = st_ff;
		nxt_st.aclk_q = port_ctl.aclk;
		case (st_ff.st)
			ST_ADDR:
			begin
				// Strobes with the data-port select high belong to the ancillary path.
				if (strobe && !port_ctl.anc_or_control_select)                   // RULE5
				begin
					nxt_st.addr = ad_in;
					nxt_st.st   = port_ctl.rd_wr ? ST_RDATA : ST_WDATA;
				end
			end
			ST_WDATA:
			begin
				if (strobe)
				begin
					nxt_st.st = ST_ADDR;
					if (is_pin)
					begin
						nxt_st.route[pin_idx] = ad_in[5:0];                      // RULE6
					end
					else if (st_ff.addr == ADDR_TEST0)
					begin
						nxt_st.test_en = ad_in[3:0];                             // RULE7
					end
				end
			end
			ST_RDATA:
			begin
				if (strobe)
				begin
					nxt_st.st = ST_ADDR;
					if (st_ff.addr == ADDR_TEST0)
					begin
						nxt_st.test_en = TEST_EN_RST;                            // RULE8
					end
				end
			end
			default:
			begin
				nxt_st.st = ST_ADDR;
			end
		endcase

		// The host turns the bus round before the data strobe; the device drives only then.
		nxt_st.ad_oe = (nxt_st.st == ST_RDATA);
		nxt_st.ad_o  = (nxt_st.st == ST_RDATA) ? rd_data : 10'h000;

		nxt_st.io_o       = drv_val & drv_en;                                   // RULE2
		nxt_st.io_oe      = drv_en;
		nxt_st.ctrl_valid = '0;
		nxt_st.ctrl_val   = '0;
		for (int i = 0; i < IOP_PINS; i++)
		begin
			nxt_st.ctrl_valid = nxt_st.ctrl_valid | in_hot[i];                  // RULE4
			nxt_st.ctrl_val   = nxt_st.ctrl_val | (in_hot[i] & {32{io_in[i]}});
		end

		nxt_st.pat_act = pattern_generator_en | built_in_self_check_en;        // RULE14
		if (nxt_st.pat_act)
		begin
			nxt_st.pat.hd         = pattern_select[PAT_HD_BIT];                 // RULE13
			nxt_st.pat.prog_pal   = pattern_select[PAT_PP_BIT];
			nxt_st.pat.sub_format = pattern_select[3:2];
			nxt_st.pat.kind       = iop_pat_kind_t'(pattern_select[1:0]);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_ff            <= '0;
			st_ff.st         <= ST_ADDR;
			st_ff.route      <= {RST_PIN7, RST_PIN6, RST_PIN5, RST_PIN4,
			                     RST_PIN3, RST_PIN2, RST_PIN1, RST_PIN0};
			st_ff.test_en    <= TEST_EN_RST;                                     // RULE9
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign ad_out         = st_ff.ad_o;
	assign ad_oe          = st_ff.ad_oe;
	assign io_out         = st_ff.io_o;
	assign io_oe          = st_ff.io_oe;
	assign pin_ctrl_val   = st_ff.ctrl_val;
	assign pin_ctrl_valid = st_ff.ctrl_valid;
	assign scrambler_en   = st_ff.test_en[TEN_SCRAMBLE];                        // RULE9
	assign nrzi_en        = st_ff.test_en[TEN_NRZI];                            // RULE10
	assign lsb_clip_en    = st_ff.test_en[TEN_LSB_CLIP];                        // RULE11
	assign sync_detect_en = st_ff.test_en[TEN_SYNC_DET];                        // RULE12
	assign pattern_cfg    = st_ff.pat;
	assign pattern_active = st_ff.pat_act;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_addr_taken;
		st_ff.st == ST_ADDR && strobe && !port_ctl.anc_or_control_select && !port_ctl.rd_wr;
	endsequence

	sequence s_data_taken;
		st_ff.st == ST_WDATA && strobe;
	endsequence

	a_addr_capture: assert property (s_addr_taken |=> st_ff.st == ST_WDATA && st_ff.addr == $past(ad_in)) // RULE5
		else $error("address phase not captured");
	a_write_pin0: assert property ((s_data_taken and (st_ff.addr == ADDR_PIN0))
		|=> st_ff.route[0] == $past(ad_in[5:0])) // RULE6
		else $error("pin 0 route not written");
	a_write_pin7: assert property ((s_data_taken and (st_ff.addr == ADDR_PIN7))
		|=> st_ff.route[7] == $past(ad_in[5:0]) && st_ff.st == ST_ADDR) // RULE1
		else $error("pin 7 route not written");
	a_test_write: assert property ((s_data_taken and (st_ff.addr == ADDR_TEST0))
		|=> {sync_detect_en, lsb_clip_en, nrzi_en, scrambler_en} == $past(ad_in[3:0])) // RULE7
		else $error("test enables not written");
	a_test_read_on: assert property ((st_ff.st == ST_RDATA && strobe && st_ff.addr == ADDR_TEST0)
		|=> scrambler_en && nrzi_en && lsb_clip_en && sync_detect_en) // RULE8
		else $error("test read did not restore enables");
	a_pin_dir: assert property (resetn |=> io_oe[0] == !$past(st_ff.route[0][ROUTE_DIR_BIT])) // RULE2
		else $error("pin 0 direction wrong");
	a_pin_func: assert property ((resetn && !st_ff.route[3][ROUTE_DIR_BIT])
		|=> io_out[3] == $past(status_bits[st_ff.route[3][ROUTE_FN_MSB:0]])) // RULE4
		else $error("pin 3 output not routed");
	a_pat_decode: assert property ((pattern_generator_en || built_in_self_check_en)
		|=> pattern_active && pattern_cfg == $past(pattern_select)) // RULE13
		else $error("pattern select not decoded");
	a_read_drive: assert property ((st_ff.st == ST_RDATA) |-> ad_oe ##1 (st_ff.st == ST_RDATA || !ad_oe)) // RULE5
		else $error("read data not driven");

endmodule : iop_regs

/* dv/iop_host.sv */
// Host controller model that drives the ancillary/control data port.
`timescale 1ns/100ps
module iop_host
(
	// Clock
	input  wire logic       clk,
	// Port drive
	output iop_pkg::iop_port_ctl_t ctl,
	output logic [9:0]      ad
);
	import iop_pkg::*;
	initial
	begin
		ctl = 3'h4;
		ad  = 10'h0;
	end
	// One strobe: one clock high, then one low; AD is inverted once taken so stale data never looks held.
	task automatic stb(input logic rw, input logic [9:0] v, input logic sel);
		@(posedge clk);
		ctl <= {sel, rw, 1'b1};
		ad  <= v;
		@(posedge clk);
		ctl.aclk <= 1'b0;
		ad  <= ~v;
	endtask : stb
endmodule : iop_host

/* dv/test_iop_regs.sv */
// Self-checking bench for the port routing and test mode registers.
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_iop_regs;
	import iop_pkg::*;
	logic          clk = 1'b0;
	logic          resetn = 1'b0;
	iop_port_ctl_t ctl;
	logic [9:0]    ad, ad_out, exp_rd;
	logic          ad_oe, pat_act, oe_q = 1'b0, oe_qq = 1'b0;
	logic          pg_en = 1'b0, bc_en = 1'b0;
	logic [7:0]    io_in = 8'h0, io_out, io_oe;
	logic [31:0]   st = 32'h0, pv, pvld, ev, epv;
	logic [5:0]    psel = 6'h0;
	wire  [3:0]    en;
	iop_pat_t      pcfg;
	logic [5:0]    rt [8];
	logic [9:0]    q [$];
	int            n_errors = 0, comparisons = 0;
	always #50 clk = ~clk;
	iop_host iop_host_inst (.clk(clk), .ctl(ctl), .ad(ad));
	iop_regs iop_regs_inst (.clk(clk), .resetn(resetn), .port_ctl(ctl), .ad_in(ad), .ad_out(ad_out),
		.ad_oe(ad_oe), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .status_bits(st),
		.pin_ctrl_val(pv), .pin_ctrl_valid(pvld), .scrambler_en(en[0]), .nrzi_en(en[1]),
		.lsb_clip_en(en[2]), .sync_detect_en(en[3]), .pattern_select(psel),
		.pattern_generator_en(pg_en), .built_in_self_check_en(bc_en), .pattern_cfg(pcfg),
		.pattern_active(pat_act));
	// Read data is judged one cycle after AD turns round: the first driven cycle still shows the old address.
	always @(posedge clk)
	begin
		oe_q  <= ad_oe;
		oe_qq <= oe_q;
		if (ad_oe && oe_q && !oe_qq)
		begin
			exp_rd = (q.size() > 0) ? q.pop_front() : 10'h3ff;
			`CHK("read data", exp_rd, ad_out)
		end
	end
	task automatic wr(input logic [9:0] a, input logic [9:0] d);
		iop_host_inst.stb(1'b0, a, 1'b0);
		iop_host_inst.stb(1'b0, d, 1'b0);
		repeat (3) @(posedge clk);
		#1;
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [9:0] e);
		q.push_back(e);
		iop_host_inst.stb(1'b1, a, 1'b0);
		iop_host_inst.stb(1'b1, ~a, 1'b0);
		repeat (3) @(posedge clk);
		#1;
	endtask : rd
	task automatic complete_run();
		`CHK("reads pending", 0, q.size())
		$display("counts: %0d compared, %0d failed", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	initial
	begin
		#(100 * 4000);
		n_errors++;
		complete_run();
	end
	initial
	begin
		logic [5:0] r;
		logic [7:0] eoe;
		logic [7:0] eout;
		logic [3:0] t;
		void'($urandom(32'h95fc9ba1));
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		`CHK("reset oe", 8'h7f, io_oe)
		`CHK("reset en", TEST_EN_RST, en)
		$display("test reset done");
		wr(ADDR_PIN0, 10'h310);
		rd(ADDR_PIN0, 10'h010);
		rd(10'h3ff, 10'h000);
		@(posedge clk);
		st <= $urandom;
		io_in <= $urandom;
		foreach (rt[i])
		begin
			r = 6'($urandom);
			wr(10'(ADDR_PIN0 + i), {4'h0, r});
			rt[i] = r;
		end
		foreach (rt[i]) rd(10'(ADDR_PIN0 + i), {4'h0, rt[i]});
		// Select high in the address phase must leave pin 0 untouched.
		iop_host_inst.stb(1'b0, ADDR_PIN0, 1'b1);
		iop_host_inst.stb(1'b0, 10'h02a, 1'b1);
		rd(ADDR_PIN0, {4'h0, rt[0]});
		eoe = '0;
		eout = '0;
		ev = '0;
		epv = '0;
		foreach (rt[i])
		begin
			eoe[i] = !rt[i][ROUTE_DIR_BIT];
			eout[i] = eoe[i] & st[rt[i][ROUTE_FN_MSB:0]];
			if (!eoe[i])
			begin
				ev[rt[i][ROUTE_FN_MSB:0]] = 1'b1;
				epv[rt[i][ROUTE_FN_MSB:0]] = epv[rt[i][ROUTE_FN_MSB:0]] | io_in[i];
			end
		end
		`CHK("pin oe", eoe, io_oe)
		`CHK("pin out", eout, io_out)
		`CHK("pin valid", ev, pvld)
		`CHK("pin value", epv, pv)
		$display("test routing done");
		for (int k = 0; k < 6; k++)
		begin
			t = (k == 0) ? 4'h0 : 4'($urandom);
			wr(ADDR_TEST0, {6'h0, t});
			`CHK("test en", t, en)
			rd(ADDR_TEST0, {6'h0, t});
			`CHK("test reload", TEST_EN_RST, en)
		end
		$display("test enables done");
		for (int p = 0; p < 64; p++)
		begin
			@(posedge clk);
			psel <= 6'(p);
			pg_en <= p[0];
			bc_en <= !p[0];
			repeat (3) @(posedge clk);
			#1;
			`CHK("pattern", 6'(p), pcfg)
			`CHK("pat active", 1'b1, pat_act)
		end
		@(posedge clk);
		pg_en <= 1'b0;
		bc_en <= 1'b0;
		psel <= 6'h15;
		repeat (3) @(posedge clk);
		#1;
		`CHK("pattern held", 6'h3f, pcfg)
		`CHK("pat idle", 1'b0, pat_act)
		$display("test pattern done");
		complete_run();
	end
endmodule : test_iop_regs
